// ---- verilog/supply_fault_irq.sv ----
// Chosen here: register access over Avalon-MM.
`timescale 1ns/100ps
// Summary of operation
// - Four LDO undervoltage flags sit at bits 11:8 of the undervoltage status, LDO4 high, each set on a rising edge.
// - Four buck undervoltage flags sit at bits 3:0 of the undervoltage status, converter 4 high, set on rising edges.
// - Undervoltage mask bits 11:0 block their flags from the group interrupt when 1 and reset to 0.
// - Reading a status register clears the flags that it holds.
// - The LED sink flag at bit 13 of status two sets on a rising edge of the loss of drain regulation.
// - Mask bit 13 of the status two mask blocks the sink flag from the sink group interrupt and resets to 0.
// - The comparator status holds usb change at bit 15, wall change at bit 14 and battery change at bit 13.
// - Each supply change flag sets on both rising and falling edges of its feedback signal.
// - Comparator mask bits 15:13 block the supply change flags from the external interrupt and reset to 0.
// - A masked flag is still captured and held.
// - A group interrupt is high while any flag of the group is set and not masked.
module supply_fault_irq (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_reset_n,
   // avalon-mm slave
   input wire logic [7:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   output logic [31:0] o_avs_readdata,
   output logic o_avs_waitrequest,
   // monitored conditions, bit 3 is regulator 4
   input wire logic [3:0] i_ldo_undervolt,
   input wire logic [3:0] i_buck_undervolt,
   input wire logic i_led_sink_unregulated,
   input wire logic i_usb_supply_feedback,
   input wire logic i_wall_supply_feedback,
   input wire logic i_battery_supply_feedback,
   // group interrupts to first level
   output logic o_undervoltage_group_irq,
   output logic o_current_sink_group_irq,
   output logic o_external_supply_group_irq
);

   // condition vector: [11:8] ldo, [7:4] buck, [3] sink, [2] usb, [1] wall, [0] battery
   logic [11:0] cond_s1_r;
   logic [11:0] cond_s2_r;
   logic [11:0] cond_s3_r;
   logic [11:0] cond_ev;

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         cond_s1_r <= 12'h000;
         cond_s2_r <= 12'h000;
         cond_s3_r <= 12'h000;
      end else begin
         cond_s1_r <= {i_ldo_undervolt, i_buck_undervolt, i_led_sink_unregulated,
                       i_usb_supply_feedback, i_wall_supply_feedback, i_battery_supply_feedback};
         cond_s2_r <= cond_s1_r;
         cond_s3_r <= cond_s2_r;
      end
   end

   // rising edges for regulator and sink
   assign cond_ev[11:3] = cond_s2_r[11:3] & ~cond_s3_r[11:3];
   assign cond_ev[2:0] = cond_s2_r[2:0] ^ cond_s3_r[2:0];

   // flag events placed in register layout
   logic [3:0] ldo_ev;
   logic [3:0] buck_ev;
   logic sink_ev;
   logic [2:0] ext_ev;
   assign ldo_ev = cond_ev[11:8];
   assign buck_ev = cond_ev[7:4];
   assign sink_ev = cond_ev[3];
   assign ext_ev = cond_ev[2:0];

   // bus state
   supply_irq_pkg::bus_state_t state_r;
   logic wait_r;
   logic [31:0] rdata_r;
   logic req;
   logic commit;
   logic take;
   assign req = i_avs_read | i_avs_write;
   assign take = req && (state_r == supply_irq_pkg::BUS_TAKE);
   assign commit = req && (state_r == supply_irq_pkg::BUS_ANSWER);

   // address decode
   logic sel_sts2;
   logic sel_uv;
   logic sel_cmp;
   logic sel_sts2_m;
   logic sel_uv_m;
   logic sel_cmp_m;
   assign sel_sts2 = i_avs_address == supply_irq_pkg::ADDR_INT_STATUS_TWO;
   assign sel_uv = i_avs_address == supply_irq_pkg::ADDR_UV_STATUS;
   assign sel_cmp = i_avs_address == supply_irq_pkg::ADDR_CMP_STATUS;
   assign sel_sts2_m = i_avs_address == supply_irq_pkg::ADDR_INT_STATUS_TWO_MASK;
   assign sel_uv_m = i_avs_address == supply_irq_pkg::ADDR_UV_MASK;
   assign sel_cmp_m = i_avs_address == supply_irq_pkg::ADDR_CMP_MASK;

   // status and mask registers
   logic [3:0] ldo_flag_r;
   logic [3:0] buck_flag_r;
   logic sink_flag_r;
   logic [2:0] ext_flag_r;
   logic [11:0] uv_mask_r;
   logic sink_mask_r;
   logic [2:0] ext_mask_r;

   // read view of each register
   logic [15:0] uv_view;
   logic [15:0] sts2_view;
   logic [15:0] cmp_view;
   logic [15:0] sts2_m_view;
   logic [15:0] uv_m_view;
   logic [15:0] cmp_m_view;
   logic [15:0] rd_mux;
   assign uv_view = {4'h0, ldo_flag_r, 4'h0, buck_flag_r};
   assign sts2_view = {2'b00, sink_flag_r, 13'h0000};
   assign cmp_view = {ext_flag_r, 13'h0000};
   assign sts2_m_view = {2'b00, sink_mask_r, 13'h0000};
   assign uv_m_view = {4'h0, uv_mask_r};
   assign cmp_m_view = {ext_mask_r, 13'h0000};
   assign rd_mux = sel_uv ? uv_view :
                   sel_sts2 ? sts2_view :
                   sel_cmp ? cmp_view :
                   sel_sts2_m ? sts2_m_view :
                   sel_uv_m ? uv_m_view :
                   sel_cmp_m ? cmp_m_view : 16'h0000;

   // bus handshake: take, answer one cycle later
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         state_r <= supply_irq_pkg::BUS_TAKE;
         wait_r <= 1'b1;
         rdata_r <= supply_irq_pkg::DATA_ZERO;
      end else if (take) begin
         state_r <= supply_irq_pkg::BUS_ANSWER;
         wait_r <= 1'b0;
         rdata_r <= {16'h0000, rd_mux};
      end else begin
         state_r <= supply_irq_pkg::BUS_TAKE;
         wait_r <= 1'b1;
      end
   end

   assign o_avs_waitrequest = wait_r;
   assign o_avs_readdata = rdata_r;

   // clear only the bits already returned to software
   logic rd_commit;
   logic wr_commit;
   logic [3:0] ldo_clr;
   logic [3:0] buck_clr;
   logic sink_clr;
   logic [2:0] ext_clr;
   assign rd_commit = commit && i_avs_read;
   assign wr_commit = commit && i_avs_write;
   assign ldo_clr = (rd_commit && sel_uv) ? rdata_r[11:8] : 4'h0;
   assign buck_clr = (rd_commit && sel_uv) ? rdata_r[3:0] : 4'h0;
   assign sink_clr = rd_commit && sel_sts2 && rdata_r[supply_irq_pkg::SINK_FLAG_BIT];
   assign ext_clr = (rd_commit && sel_cmp) ? rdata_r[15:13] : 3'h0;

   // set wins over clear; capture regardless of mask
   logic [3:0] ldo_flag_nxt;
   logic [3:0] buck_flag_nxt;
   logic sink_flag_nxt;
   logic [2:0] ext_flag_nxt;
   assign ldo_flag_nxt = (ldo_flag_r & ~ldo_clr) | ldo_ev;
   assign buck_flag_nxt = (buck_flag_r & ~buck_clr) | buck_ev;
   assign sink_flag_nxt = (sink_flag_r & ~sink_clr) | sink_ev;
   assign ext_flag_nxt = (ext_flag_r & ~ext_clr) | ext_ev;

   logic [11:0] uv_mask_nxt;
   logic sink_mask_nxt;
   logic [2:0] ext_mask_nxt;
   assign uv_mask_nxt = (wr_commit && sel_uv_m) ? i_avs_writedata[supply_irq_pkg::UV_MASK_MSB:0] : uv_mask_r;
   assign sink_mask_nxt = (wr_commit && sel_sts2_m) ? i_avs_writedata[supply_irq_pkg::SINK_FLAG_BIT] : sink_mask_r;
   assign ext_mask_nxt = (wr_commit && sel_cmp_m) ? i_avs_writedata[15:13] : ext_mask_r;

   logic uv_irq_nxt;
   logic sink_irq_nxt;
   logic ext_irq_nxt;
   assign uv_irq_nxt = |({ldo_flag_nxt, 4'h0, buck_flag_nxt} & ~uv_mask_nxt);
   assign sink_irq_nxt = sink_flag_nxt & ~sink_mask_nxt;
   assign ext_irq_nxt = |(ext_flag_nxt & ~ext_mask_nxt);

   logic uv_irq_r;
   logic sink_irq_r;
   logic ext_irq_r;

   // flag, mask and interrupt registers
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         ldo_flag_r <= 4'h0;
         buck_flag_r <= 4'h0;
         sink_flag_r <= 1'b0;
         ext_flag_r <= 3'h0;
         uv_mask_r <= supply_irq_pkg::UV_MASK_RST;
         sink_mask_r <= supply_irq_pkg::SINK_MASK_RST;
         ext_mask_r <= supply_irq_pkg::EXT_MASK_RST;
         uv_irq_r <= 1'b0;
         sink_irq_r <= 1'b0;
         ext_irq_r <= 1'b0;
      end else begin
         ldo_flag_r <= ldo_flag_nxt;
         buck_flag_r <= buck_flag_nxt;
         sink_flag_r <= sink_flag_nxt;
         ext_flag_r <= ext_flag_nxt;
         uv_mask_r <= uv_mask_nxt;
         sink_mask_r <= sink_mask_nxt;
         ext_mask_r <= ext_mask_nxt;
         uv_irq_r <= uv_irq_nxt;
         sink_irq_r <= sink_irq_nxt;
         ext_irq_r <= ext_irq_nxt;
      end
   end

   assign o_undervoltage_group_irq = uv_irq_r;
   assign o_current_sink_group_irq = sink_irq_r;
   assign o_external_supply_group_irq = ext_irq_r;

   // checks
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_reset_n);

   // a request is answered one cycle after it is taken
   sequence s_taken;
      req && wait_r;
   endsequence
   sequence s_answered;
      !wait_r ##1 wait_r;
   endsequence

   chk_bus_answer_timing: assert property (s_taken |=> s_answered)
      else $error("bus answer not one cycle after take");

   chk_ldo_flag_set: assert property ((|ldo_ev) |=> ((ldo_flag_r & $past(ldo_ev)) == $past(ldo_ev)))
      else $error("ldo undervoltage edge not captured");

   // buck edge sets flag two stages after input rise
   chk_buck_rise_path: assert property ($rose(i_buck_undervolt[0]) ##1 i_buck_undervolt[0] ##1 i_buck_undervolt[0]
                                        |=> buck_flag_r[0])
      else $error("buck undervoltage rise not flagged");

   // undervoltage interrupt follows flags and mask
   chk_uv_irq_mask: assert property (uv_irq_r == |({ldo_flag_r, 4'h0, buck_flag_r} & ~uv_mask_r))
      else $error("undervoltage interrupt disagrees with flags and mask");

   // a clearing read without new events empties the register
   sequence s_uv_read_clear;
      rd_commit && sel_uv && !(|ldo_ev) && !(|buck_ev) && !$past(|ldo_ev) && !$past(|buck_ev);
   endsequence
   chk_uv_read_clear: assert property (s_uv_read_clear |=> (ldo_flag_r == 4'h0) && (buck_flag_r == 4'h0))
      else $error("undervoltage status not cleared by read");

   chk_sink_flag_set: assert property (sink_ev |=> sink_flag_r)
      else $error("sink regulation edge not captured");

   // sink interrupt follows flag and mask
   chk_sink_irq_mask: assert property (sink_irq_r == (sink_flag_r && !sink_mask_r))
      else $error("sink interrupt disagrees with flag and mask");

   // falling usb feedback also reported at bit 15
   chk_usb_fall_seen: assert property ($fell(cond_s2_r[2]) |=> ext_flag_r[2] && cmp_view[supply_irq_pkg::USB_FLAG_BIT])
      else $error("usb feedback fall not flagged");

   // external interrupt follows flags and mask
   chk_ext_irq_mask: assert property (ext_irq_r == |(ext_flag_r & ~ext_mask_r))
      else $error("external interrupt disagrees with flags and mask");

   // masked flag still captured and irq stays low
   chk_masked_capture: assert property ((&ext_mask_nxt) && (|ext_ev) |=> (|ext_flag_r) && !ext_irq_r)
      else $error("masked flag lost or raised interrupt");

   // an unmasked ldo event raises the undervoltage group line the next cycle
   chk_group_raise: assert property ((|(ldo_ev & ~uv_mask_nxt[11:8])) |=> uv_irq_r)
      else $error("unmasked undervoltage event did not raise group");

   // set wins over clear in the same cycle
   chk_set_wins: assert property (ext_clr[0] && ext_ev[0] |=> ext_flag_r[0])
      else $error("event lost during clearing read");

   // mask write lands at the commit edge
   chk_uv_mask_write: assert property (wr_commit && sel_uv_m |=> uv_mask_r == $past(i_avs_writedata[11:0]))
      else $error("undervoltage mask write not stored");

   // a falling ldo condition sets no flag
   chk_ldo_fall_quiet: assert property ($fell(cond_s2_r[9]) && !ldo_flag_r[1] |=> !ldo_flag_r[1])
      else $error("ldo undervoltage fall raised a flag");

   // a falling buck condition sets no flag
   chk_buck_fall_quiet: assert property ($fell(cond_s2_r[4]) && !buck_flag_r[0] |=> !buck_flag_r[0])
      else $error("buck undervoltage fall raised a flag");

   // a rising wall feedback is reported
   chk_wall_rise_seen: assert property ($rose(cond_s2_r[1]) |=> ext_flag_r[1])
      else $error("wall feedback rise not flagged");

   // any battery feedback change is reported
   chk_batt_change_seen: assert property ($changed(cond_s2_r[0]) |=> ext_flag_r[0])
      else $error("battery feedback change not flagged");

   // comparator read with a quiet take and commit empties it
   sequence s_cmp_read_clear;
      rd_commit && sel_cmp && !(|ext_ev) && !$past(|ext_ev);
   endsequence
   chk_cmp_read_clear: assert property (s_cmp_read_clear |=> ext_flag_r == 3'h0)
      else $error("comparator status not cleared by read");

   // status two read with a quiet take and commit clears it
   sequence s_sink_read_clear;
      rd_commit && sel_sts2 && !sink_ev && !$past(sink_ev);
   endsequence
   chk_sink_read_clear: assert property (s_sink_read_clear |=> !sink_flag_r)
      else $error("sink status not cleared by read");

   // undervoltage mask changes only on a write
   chk_uv_mask_hold: assert property (!(wr_commit && sel_uv_m) |=> $stable(uv_mask_r))
      else $error("undervoltage mask changed without a write");

   // sink mask changes only on a write
   chk_sink_mask_hold: assert property (!(wr_commit && sel_sts2_m) |=> $stable(sink_mask_r))
      else $error("sink mask changed without a write");

   // comparator mask changes only on a write
   chk_ext_mask_hold: assert property (!(wr_commit && sel_cmp_m) |=> $stable(ext_mask_r))
      else $error("comparator mask changed without a write");

   // masked sink event held but silent
   chk_masked_sink_quiet: assert property (sink_mask_nxt && sink_ev |=> sink_flag_r && !sink_irq_r)
      else $error("masked sink event lost or raised interrupt");

   // unmasked supply change raises the external group
   chk_ext_group_raise: assert property ((|(ext_ev & ~ext_mask_nxt)) |=> ext_irq_r)
      else $error("unmasked supply change did not raise group");

   // unmasked sink event raises the sink group
   chk_sink_group_raise: assert property (sink_ev && !sink_mask_nxt |=> sink_irq_r)
      else $error("unmasked sink event did not raise group");

endmodule

// ---- verilog/supply_irq_pkg.sv ----
package supply_irq_pkg;
   // register indices; byte address is four times the index
   localparam logic [7:0] IDX_INT_STATUS_TWO = 8'h1a;
   localparam logic [7:0] IDX_UV_STATUS = 8'h1c;
   localparam logic [7:0] IDX_CMP_STATUS = 8'h1f;
   localparam logic [7:0] IDX_INT_STATUS_TWO_MASK = 8'h22;
   localparam logic [7:0] IDX_UV_MASK = 8'h24;
   localparam logic [7:0] IDX_CMP_MASK = 8'h27;
   localparam logic [7:0] ADDR_INT_STATUS_TWO = {IDX_INT_STATUS_TWO[5:0], 2'b00};
   localparam logic [7:0] ADDR_UV_STATUS = {IDX_UV_STATUS[5:0], 2'b00};
   localparam logic [7:0] ADDR_CMP_STATUS = {IDX_CMP_STATUS[5:0], 2'b00};
   localparam logic [7:0] ADDR_INT_STATUS_TWO_MASK = {IDX_INT_STATUS_TWO_MASK[5:0], 2'b00};
   localparam logic [7:0] ADDR_UV_MASK = {IDX_UV_MASK[5:0], 2'b00};
   localparam logic [7:0] ADDR_CMP_MASK = {IDX_CMP_MASK[5:0], 2'b00};

   // field positions
   localparam int LDO_FLAG_LSB = 8;
   localparam int LDO_FLAG_MSB = 11;
   localparam int BUCK_FLAG_LSB = 0;
   localparam int BUCK_FLAG_MSB = 3;
   localparam int UV_MASK_MSB = 11;
   localparam int SINK_FLAG_BIT = 13;
   localparam int BATT_FLAG_BIT = 13;
   localparam int WALL_FLAG_BIT = 14;
   localparam int USB_FLAG_BIT = 15;

   // reset values
   localparam logic [11:0] UV_MASK_RST = 12'h000;
   localparam logic SINK_MASK_RST = 1'b0;
   localparam logic [2:0] EXT_MASK_RST = 3'h0;
   localparam logic [31:0] DATA_ZERO = 32'h0000_0000;

   // bus answer states, one-hot
   typedef enum logic [1:0] {
      BUS_TAKE = 2'b01,
      BUS_ANSWER = 2'b10
   } bus_state_t;
endpackage

// ---- verif/supply_fault_irq_tb.sv ----
`timescale 1ns/100ps
module supply_fault_irq_tb;
   // bench stimulus and observed outputs
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic [7:0] addr = 8'h00;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic [31:0] wdata = 32'h0000_0000;
   logic [3:0] ldo = 4'h0;
   logic [3:0] buck = 4'h0;
   logic sink = 1'b0;
   logic [2:0] fb = 3'h0; // usb, wall, battery
   logic [31:0] rdata;
   logic waitreq;
   logic [2:0] irqs; // undervoltage, sink, external
   logic [31:0] got;
   int mismatches = 0;
   int checks_done = 0;
   int cycles = 0;

   // one condition case: inputs to pulse, status to read, expected flags and group irqs
   typedef struct {
      logic [3:0] ldo;
      logic [3:0] buck;
      logic sink;
      logic [2:0] fb;
      logic [7:0] addr;
      logic [31:0] flags;
      logic [2:0] irqs;
   } row_t;
   row_t rows [8] = '{
      '{4'h8, 4'h0, 1'b0, 3'h0, supply_irq_pkg::ADDR_UV_STATUS, 32'h0000_0800, 3'h4},
      '{4'h1, 4'h0, 1'b0, 3'h0, supply_irq_pkg::ADDR_UV_STATUS, 32'h0000_0100, 3'h4},
      '{4'h0, 4'h8, 1'b0, 3'h0, supply_irq_pkg::ADDR_UV_STATUS, 32'h0000_0008, 3'h4},
      '{4'h0, 4'h5, 1'b0, 3'h0, supply_irq_pkg::ADDR_UV_STATUS, 32'h0000_0005, 3'h4},
      '{4'h0, 4'h0, 1'b1, 3'h0, supply_irq_pkg::ADDR_INT_STATUS_TWO, 32'h0000_2000, 3'h2},
      '{4'h0, 4'h0, 1'b0, 3'h4, supply_irq_pkg::ADDR_CMP_STATUS, 32'h0000_8000, 3'h1},
      '{4'h0, 4'h0, 1'b0, 3'h2, supply_irq_pkg::ADDR_CMP_STATUS, 32'h0000_4000, 3'h1},
      '{4'h0, 4'h0, 1'b0, 3'h1, supply_irq_pkg::ADDR_CMP_STATUS, 32'h0000_2000, 3'h1}
   };
   logic [7:0] masks [3] = '{supply_irq_pkg::ADDR_UV_MASK, supply_irq_pkg::ADDR_INT_STATUS_TWO_MASK,
      supply_irq_pkg::ADDR_CMP_MASK};
   logic [31:0] mask_full [3] = '{32'h0000_0FFF, 32'h0000_2000, 32'h0000_E000};

   supply_fault_irq i_supply_fault_irq (
      .i_clk(clk),
      .i_reset_n(reset_n),
      .i_avs_address(addr),
      .i_avs_read(rd),
      .i_avs_write(wr),
      .i_avs_writedata(wdata),
      .o_avs_readdata(rdata),
      .o_avs_waitrequest(waitreq),
      .i_ldo_undervolt(ldo),
      .i_buck_undervolt(buck),
      .i_led_sink_unregulated(sink),
      .i_usb_supply_feedback(fb[2]),
      .i_wall_supply_feedback(fb[1]),
      .i_battery_supply_feedback(fb[0]),
      .o_undervoltage_group_irq(irqs[2]),
      .o_current_sink_group_irq(irqs[1]),
      .o_external_supply_group_irq(irqs[0])
   );

   // clock
   always #25 clk = ~clk;

   // verdict and end of run
   task stop_test;
      $display("counts: mismatches=%0d checks=%0d", mismatches, checks_done);
      if (mismatches == 0 && checks_done > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   // hang guard
   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         mismatches++;
         stop_test;
      end
   end

   task chk(input logic [31:0] g, input logic [31:0] e);
      checks_done++;
      if (g !== e) begin
         mismatches++;
         $display("MISMATCH at %0t: got %h expected %h", $time, g, e);
      end
   endtask

   // one avalon access, held until waitrequest is sampled low
   task bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      @(posedge clk);
      addr <= a;
      rd <= ~w;
      wr <= w;
      wdata <= d;
      do begin
         @(posedge clk);
      end while (waitreq !== 1'b0);
      q = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask

   task drive(input logic [3:0] l, input logic [3:0] b, input logic s, input logic [2:0] f, input int n);
      @(posedge clk);
      ldo <= l;
      buck <= b;
      sink <= s;
      fb <= f;
      repeat (n) @(posedge clk);
      @(negedge clk);
   endtask

   initial begin
      repeat (5) @(posedge clk);
      chk({31'h0, waitreq}, 32'h0000_0001);
      chk({29'h0, irqs}, 32'h0000_0000);
      reset_n <= 1'b1;
      // eight cases, each pulsing conditions of one group only, read twice
      foreach (rows[i]) begin
         drive(rows[i].ldo, rows[i].buck, rows[i].sink, rows[i].fb, 4);
         chk({29'h0, irqs}, {29'h0, rows[i].irqs});
         drive(4'h0, 4'h0, 1'b0, 3'h0, 5);
         bus(1'b0, rows[i].addr, 32'h0000_0000, got);
         chk(got, rows[i].flags);
         bus(1'b0, rows[i].addr, 32'h0000_0000, got);
         chk(got, 32'h0000_0000);
      end
      // mask defaults, then full write and readback
      for (int i = 0; i < 3; i++) begin
         bus(1'b0, masks[i], 32'h0000_0000, got);
         chk(got, 32'h0000_0000);
         bus(1'b1, masks[i], 32'hFFFF_FFFF, got);
         bus(1'b0, masks[i], 32'h0000_0000, got);
         chk(got, mask_full[i]);
      end
      bus(1'b0, 8'h00, 32'h0000_0000, got);
      chk(got, 32'h0000_0000);
      // masked events still captured but raise no group irq
      drive(4'h4, 4'h0, 1'b1, 3'h4, 5);
      chk({29'h0, irqs}, 32'h0000_0000);
      drive(4'h0, 4'h0, 1'b0, 3'h4, 4);
      for (int i = 0; i < 3; i++) bus(1'b1, masks[i], 32'h0000_0000, got);
      @(negedge clk);
      chk({29'h0, irqs}, 32'h0000_0007);
      bus(1'b0, supply_irq_pkg::ADDR_UV_STATUS, 32'h0000_0000, got);
      chk(got, 32'h0000_0400);
      bus(1'b0, supply_irq_pkg::ADDR_INT_STATUS_TWO, 32'h0000_0000, got);
      chk(got, 32'h0000_2000);
      bus(1'b0, supply_irq_pkg::ADDR_CMP_STATUS, 32'h0000_0000, got);
      chk(got, 32'h0000_8000);
      @(negedge clk);
      chk({29'h0, irqs}, 32'h0000_0000);
      // falling feedback edge alone sets the change flag
      drive(4'h0, 4'h0, 1'b0, 3'h0, 5);
      chk({29'h0, irqs}, 32'h0000_0001);
      bus(1'b0, supply_irq_pkg::ADDR_CMP_STATUS, 32'h0000_0000, got);
      chk(got, 32'h0000_8000);
      // set wins: a battery change lands in the commit cycle of the clearing read
      drive(4'h0, 4'h0, 1'b0, 3'h1, 5);
      @(posedge clk);
      fb <= 3'h0;
      bus(1'b0, supply_irq_pkg::ADDR_CMP_STATUS, 32'h0000_0000, got);
      chk(got, 32'h0000_2000);
      bus(1'b0, supply_irq_pkg::ADDR_CMP_STATUS, 32'h0000_0000, got);
      chk(got, 32'h0000_2000);
      // mid-run reset; conditions held high count as fresh edges after release
      drive(4'h2, 4'h1, 1'b0, 3'h0, 4);
      bus(1'b1, supply_irq_pkg::ADDR_UV_MASK, 32'h0000_0001, got);
      bus(1'b0, supply_irq_pkg::ADDR_UV_MASK, 32'h0000_0000, got);
      @(posedge clk);
      reset_n <= 1'b0;
      @(negedge clk);
      chk({28'h0, waitreq, irqs}, 32'h0000_0008);
      chk(rdata, 32'h0000_0000);
      repeat (2) @(posedge clk);
      reset_n <= 1'b1;
      repeat (2) @(negedge clk);
      chk({28'h0, waitreq, irqs}, 32'h0000_0008);
      bus(1'b0, supply_irq_pkg::ADDR_UV_MASK, 32'h0000_0000, got);
      chk(got, 32'h0000_0000);
      @(negedge clk);
      chk({29'h0, irqs}, 32'h0000_0004);
      bus(1'b0, supply_irq_pkg::ADDR_UV_STATUS, 32'h0000_0000, got);
      chk(got, 32'h0000_0201);
      drive(4'h0, 4'h0, 1'b0, 3'h0, 5);
      chk({29'h0, irqs}, 32'h0000_0000);
      stop_test;
   end
endmodule
